//--- rtl/pasd_defines.svh
// Purpose: constants for the port A strap default block
// Assumes: included by bare name from rtl/
// Notes: definitions only
`ifndef PASD_DEFINES_SVH
`define PASD_DEFINES_SVH

// strap values used when the pin is left to its internal resistor
`define PASD_RST_FIBER 1'h0
`define PASD_RST_AUTONEG 1'h1
`define PASD_RST_SPEED 1'h1
`define PASD_RST_DUPLEX 1'h1
`define PASD_RST_BACKPRESSURE 1'h1
`define PASD_RST_FDX_PAUSE 1'h1
`define PASD_RST_FORCED_PAUSE 1'h0

// cycles the pin synchronisers need before a capture is trusted
`define PASD_SETTLE_CYC 2'h2

// phy mode codes used by the derivation
`define PASD_MODE_ALL_CAPABLE 3'h7
`define PASD_MODE_FIBER 3'h0

// register byte offsets
`define PASD_ADDR_LATCHED 8'h00
`define PASD_ADDR_ACTIVE 8'h04
`define PASD_ADDR_BASE_CTRL 8'h08
`define PASD_ADDR_ADVERTISE 8'h0C
`define PASD_ADDR_OP_MODES 8'h10
`define PASD_ADDR_PORT_ONE 8'h14
`define PASD_ADDR_CONTROL 8'h18
`define PASD_ADDR_STATUS 8'h1C

// control register fields
`define PASD_CTL_FREEZE_BIT 0
`define PASD_CTL_RESTORE_BIT 1
`define PASD_CTL_RST 1'h0

`endif

//--- rtl/pasd_derive.sv
// Purpose: maps strap values to phy and port one register defaults
// Assumes: purely combinational, registered by the caller
// Notes: mode codes are parameters so the mapping can be retargeted
`default_nettype none
`include "pasd_defines.svh"
module pasd_derive #(
   parameter logic [2:0] MODE_ALL = `PASD_MODE_ALL_CAPABLE,
   parameter logic [2:0] MODE_FX = `PASD_MODE_FIBER
) (
   input wire pasd_pkg::pasd_straps_s straps_in, // effective straps
   output pasd_pkg::pasd_dflt_s dflt_out // derived defaults
);
   import pasd_pkg::*;

   logic an;
   logic fx;

   assign fx = straps_in.phy_fiber_mode_strap;
   // fiber mode masks autoneg, speed and the phy pause adverts, not the port one pause bits
   assign an = straps_in.phy_autoneg_default_strap & ~fx;

   always_comb
   begin
      dflt_out = '0;
      dflt_out.phy_autoneg_enable_bit = an;
      dflt_out.phy_rate_select_low_bit = fx | an | straps_in.phy_rate_default_strap;
      dflt_out.phy_fdx_bit = (an & ~fx) | straps_in.phy_fdx_default_strap;
      dflt_out.phy_adv_10_hdx_bit = ~fx & (an | ~straps_in.phy_rate_default_strap);
      dflt_out.phy_adv_10_fdx_bit = ~fx & (an | ~straps_in.phy_rate_default_strap)
         & straps_in.phy_fdx_default_strap;
      dflt_out.phy_asym_pause_bit = ~fx & straps_in.port_one_fdx_pause_default_strap
         & ~straps_in.port_one_forced_pause_default_strap;
      dflt_out.phy_sym_pause_bit = ~fx & ~straps_in.port_one_forced_pause_default_strap;
      if (fx)
      begin
         dflt_out.phy_mode_field = MODE_FX;
      end
      else if (an)
      begin
         dflt_out.phy_mode_field = MODE_ALL;
      end
      else
      begin
         dflt_out.phy_mode_field = {1'b0, straps_in.phy_rate_default_strap,
            straps_in.phy_fdx_default_strap};
      end
      // port one bits are configured straight from their straps
      dflt_out.port_one_backpressure_bit = straps_in.port_one_backpressure_default_strap;
      dflt_out.port_one_tx_pause_enable_bit = straps_in.port_one_fdx_pause_default_strap;
      dflt_out.port_one_rx_pause_enable_bit = straps_in.port_one_fdx_pause_default_strap;
      dflt_out.port_one_forced_pause_select = straps_in.port_one_forced_pause_default_strap;
   end

endmodule : pasd_derive
`default_nettype wire

//--- rtl/pasd_pkg.sv
// Purpose: types shared by the port A strap default block
// Assumes: nothing
// Notes: strap and default bundles are packed structs
`default_nettype none
package pasd_pkg;

   typedef struct packed {
      logic phy_fiber_mode_strap;
      logic phy_autoneg_default_strap;
      logic phy_rate_default_strap;
      logic phy_fdx_default_strap;
      logic port_one_backpressure_default_strap;
      logic port_one_fdx_pause_default_strap;
      logic port_one_forced_pause_default_strap;
   } pasd_straps_s;

   typedef struct packed {
      logic phy_autoneg_enable_bit;
      logic phy_rate_select_low_bit;
      logic phy_fdx_bit;
      logic phy_adv_10_fdx_bit;
      logic phy_adv_10_hdx_bit;
      logic phy_asym_pause_bit;
      logic phy_sym_pause_bit;
      logic [2:0] phy_mode_field;
      logic port_one_backpressure_bit;
      logic port_one_tx_pause_enable_bit;
      logic port_one_rx_pause_enable_bit;
      logic port_one_forced_pause_select;
   } pasd_dflt_s;

   typedef enum logic [2:0] {
      PASD_SETTLE = 3'h1,
      PASD_CAPTURE = 3'h2,
      PASD_RUN = 3'h4
   } pasd_state_e;

   typedef struct packed {
      pasd_straps_s pin_meta;
      pasd_straps_s pin_sync;
      pasd_state_e state;
      logic [1:0] settle;
      pasd_straps_s latched;
      pasd_straps_s active;
      logic captured;
      logic freeze;
      pasd_dflt_s dflt;
      logic [31:0] rdata;
   } pasd_regs_s;

endpackage : pasd_pkg
`default_nettype wire

//--- rtl/pasd_top.sv
// Purpose: latches port A soft straps and produces register defaults
// Assumes: eeprom loader and reset sources sit on clk_in
// Notes: register port answers reads one cycle later
//
// Our own choices: the register offsets and the plain strobed port.
`default_nettype none
`include "pasd_defines.svh"
module pasd_top (
   input wire logic clk_in, // 10 MHz clock
   input wire logic nrst_in, // async reset, active low
   input wire pasd_pkg::pasd_straps_s strap_pins_in, // strap pins, asynchronous
   input wire logic eeprom_present_in, // eeprom attached and valid
   input wire logic eeprom_load_in, // pulse: loader offers strap values
   input wire pasd_pkg::pasd_straps_s eeprom_straps_in, // loader strap values
   input wire logic digital_rst_in, // pulse: digital reset
   input wire logic eeprom_reload_in, // pulse: reload command
   input wire logic [7:0] reg_addr_in, // register byte address
   input wire logic [31:0] reg_wdata_in, // register write data
   input wire logic reg_wr_in, // write strobe
   input wire logic reg_rd_in, // read strobe
   output logic [31:0] reg_rdata_out, // read data, cycle after strobe
   output pasd_pkg::pasd_dflt_s dflt_out, // register defaults
   output logic captured_out // straps have been caught
);
   import pasd_pkg::*;

   logic [1:0] rst_sync_r;
   logic rst_n;
   pasd_regs_s st_r;
   pasd_regs_s st_nxt;
   pasd_dflt_s dflt_calc;
   logic restore_req;
   logic ctl_wr;

   // reset is released through two flops, asserted at once
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_sync_r <= 2'h0;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   pasd_derive #(
      .MODE_ALL(`PASD_MODE_ALL_CAPABLE),
      .MODE_FX(`PASD_MODE_FIBER)
   ) u_derive (
      .straps_in(st_r.active),
      .dflt_out(dflt_calc)
   );

   function automatic logic [31:0] pasd_read(input logic [7:0] addr, input pasd_regs_s s,
      input logic present);
      logic [31:0] d;
      d = 32'h0;
      case (addr)
         `PASD_ADDR_LATCHED:
            d = {25'h0, s.latched};
         `PASD_ADDR_ACTIVE:
            d = {25'h0, s.active};
         `PASD_ADDR_BASE_CTRL:
            d = {29'h0, s.dflt.phy_autoneg_enable_bit, s.dflt.phy_rate_select_low_bit,
               s.dflt.phy_fdx_bit};
         `PASD_ADDR_ADVERTISE:
            d = {28'h0, s.dflt.phy_asym_pause_bit, s.dflt.phy_sym_pause_bit,
               s.dflt.phy_adv_10_fdx_bit, s.dflt.phy_adv_10_hdx_bit};
         `PASD_ADDR_OP_MODES:
            d = {29'h0, s.dflt.phy_mode_field};
         `PASD_ADDR_PORT_ONE:
            d = {28'h0, s.dflt.port_one_forced_pause_select, s.dflt.port_one_rx_pause_enable_bit,
               s.dflt.port_one_tx_pause_enable_bit, s.dflt.port_one_backpressure_bit};
         `PASD_ADDR_CONTROL:
            d = {31'h0, s.freeze};
         `PASD_ADDR_STATUS:
            d = {29'h0, (s.active != s.latched), present, s.captured};
         default:
            d = 32'h0;
      endcase
      return d;
   endfunction : pasd_read

   assign ctl_wr = reg_wr_in && (reg_addr_in == `PASD_ADDR_CONTROL);
   // a restore only makes sense when no eeprom will refill the values
   assign restore_req = (digital_rst_in | eeprom_reload_in
      | (ctl_wr & reg_wdata_in[`PASD_CTL_RESTORE_BIT])) & ~eeprom_present_in;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pin_meta = strap_pins_in;
      st_nxt.pin_sync = st_r.pin_meta;
      st_nxt.dflt = dflt_calc;
      st_nxt.rdata = 32'h0;
      if (reg_rd_in)
      begin
         st_nxt.rdata = pasd_read(reg_addr_in, st_r, eeprom_present_in);
      end
      if (ctl_wr)
      begin
         st_nxt.freeze = reg_wdata_in[`PASD_CTL_FREEZE_BIT];
      end
      case (st_r.state)
         PASD_SETTLE:
         begin
            st_nxt.settle = st_r.settle + 2'h1;
            if (st_r.settle == (`PASD_SETTLE_CYC - 2'h1))
            begin
               st_nxt.state = PASD_CAPTURE;
            end
         end
         PASD_CAPTURE:
         begin
            // pins are sampled once here and never again until reset
            st_nxt.latched = st_r.pin_sync;
            st_nxt.active = st_r.pin_sync;
            st_nxt.captured = 1'b1;
            st_nxt.state = PASD_RUN;
         end
         PASD_RUN:
         begin
            // a load in the same cycle as a restore wins unless freeze is set, it is newer data
            if (eeprom_load_in && !st_r.freeze)
            begin
               st_nxt.active = eeprom_straps_in;
            end
            else if (restore_req)
            begin
               st_nxt.active = st_r.latched;
            end
         end
         default:
         begin
            st_nxt.state = PASD_SETTLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r.pin_meta <= {`PASD_RST_FIBER, `PASD_RST_AUTONEG, `PASD_RST_SPEED, `PASD_RST_DUPLEX,
            `PASD_RST_BACKPRESSURE, `PASD_RST_FDX_PAUSE, `PASD_RST_FORCED_PAUSE};
         st_r.pin_sync <= {`PASD_RST_FIBER, `PASD_RST_AUTONEG, `PASD_RST_SPEED, `PASD_RST_DUPLEX,
            `PASD_RST_BACKPRESSURE, `PASD_RST_FDX_PAUSE, `PASD_RST_FORCED_PAUSE};
         st_r.state <= PASD_SETTLE;
         st_r.settle <= 2'h0;
         st_r.latched <= {`PASD_RST_FIBER, `PASD_RST_AUTONEG, `PASD_RST_SPEED, `PASD_RST_DUPLEX,
            `PASD_RST_BACKPRESSURE, `PASD_RST_FDX_PAUSE, `PASD_RST_FORCED_PAUSE};
         st_r.active <= {`PASD_RST_FIBER, `PASD_RST_AUTONEG, `PASD_RST_SPEED, `PASD_RST_DUPLEX,
            `PASD_RST_BACKPRESSURE, `PASD_RST_FDX_PAUSE, `PASD_RST_FORCED_PAUSE};
         st_r.captured <= 1'b0;
         st_r.freeze <= `PASD_CTL_RST;
         st_r.dflt <= '0;
         st_r.rdata <= 32'h0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_out = st_r.rdata;
   assign dflt_out = st_r.dflt;
   assign captured_out = st_r.captured;

   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);

   sequence restore_req_s;
      st_r.state == PASD_RUN && restore_req && !eeprom_load_in;
   endsequence

   sequence restore_seen_s;
      ##1 st_r.active == $past(st_r.latched) ##1 st_r.dflt == $past(dflt_calc);
   endsequence

   sequence load_req_s;
      st_r.state == PASD_RUN && eeprom_load_in && !st_r.freeze;
   endsequence

   // the release edge itself still clears the defaults, so these checks start one edge later
   autoneg_default_a: assert property (
      rst_n && !st_r.active.phy_fiber_mode_strap |=>
         st_r.dflt.phy_autoneg_enable_bit == $past(st_r.active.phy_autoneg_default_strap))
      else $error("autoneg default does not follow strap");

   autoneg_forces_a: assert property (
      rst_n && st_r.active.phy_autoneg_default_strap && !st_r.active.phy_fiber_mode_strap |=>
         st_r.dflt.phy_rate_select_low_bit && st_r.dflt.phy_fdx_bit
         && st_r.dflt.phy_mode_field == `PASD_MODE_ALL_CAPABLE)
      else $error("autoneg strap did not force speed, duplex and mode");

   speed_follows_a: assert property (
      !st_r.active.phy_autoneg_default_strap && !st_r.active.phy_fiber_mode_strap |=>
         st_r.dflt.phy_rate_select_low_bit == $past(st_r.active.phy_rate_default_strap)
         && st_r.dflt.phy_adv_10_hdx_bit == !$past(st_r.active.phy_rate_default_strap))
      else $error("speed default does not follow strap");

   duplex_follows_a: assert property (
      !st_r.active.phy_autoneg_default_strap && !st_r.active.phy_fiber_mode_strap |=>
         st_r.dflt.phy_fdx_bit == $past(st_r.active.phy_fdx_default_strap)
         && st_r.dflt.phy_mode_field[0] == $past(st_r.active.phy_fdx_default_strap))
      else $error("duplex default does not follow strap");

   fiber_masks_a: assert property (
      st_r.active.phy_fiber_mode_strap |=>
         !st_r.dflt.phy_autoneg_enable_bit && !st_r.dflt.phy_asym_pause_bit
         && !st_r.dflt.phy_sym_pause_bit && st_r.dflt.phy_mode_field == `PASD_MODE_FIBER)
      else $error("fiber mode did not mask strap effects");

   port_flow_a: assert property (
      rst_n |=> st_r.dflt.port_one_backpressure_bit == $past(st_r.active.port_one_backpressure_default_strap)
         && st_r.dflt.port_one_tx_pause_enable_bit == $past(st_r.active.port_one_fdx_pause_default_strap)
         && st_r.dflt.port_one_rx_pause_enable_bit == st_r.dflt.port_one_tx_pause_enable_bit)
      else $error("port one flow defaults do not follow straps");

   asym_pause_a: assert property (
      rst_n && !st_r.active.port_one_forced_pause_default_strap && !st_r.active.phy_fiber_mode_strap |=>
         st_r.dflt.phy_asym_pause_bit == $past(st_r.active.port_one_fdx_pause_default_strap)
         && st_r.dflt.phy_sym_pause_bit)
      else $error("asymmetric pause default wrong");

   forced_pause_a: assert property (
      st_r.active.port_one_forced_pause_default_strap |=>
         st_r.dflt.port_one_forced_pause_select && !st_r.dflt.phy_asym_pause_bit
         && !st_r.dflt.phy_sym_pause_bit)
      else $error("forced pause strap did not clear pause adverts");

   capture_time_a: assert property (
      $rose(rst_n) |-> !st_r.captured [*3] ##1 st_r.captured
         && st_r.latched == $past(st_r.pin_sync))
      else $error("straps not caught on time");

   load_override_a: assert property (
      load_req_s |=> st_r.active == $past(eeprom_straps_in))
      else $error("eeprom load did not override straps");

   restore_path_a: assert property (
      restore_req_s |-> restore_seen_s)
      else $error("restore did not bring back caught straps");

   latch_hold_a: assert property (
      st_r.state == PASD_RUN |=> $stable(st_r.latched) && st_r.captured)
      else $error("caught straps changed after capture");

   read_once_a: assert property (
      !reg_rd_in |=> reg_rdata_out == 32'h0)
      else $error("read data outside the answer cycle");

endmodule : pasd_top
`default_nettype wire

//--- sim/pasd_far_model.sv
// Purpose: far side model, strap pins and eeprom loader
// Assumes: bench commands change just after a rising edge
// Notes: idle loader data toggles every cycle so a stale value never passes
`default_nettype none
module pasd_far_model (
   input wire logic clk_in, // device clock
   input wire logic go_in, // bench asks for one load
   input wire pasd_pkg::pasd_straps_s data_in, // values to load
   input wire pasd_pkg::pasd_straps_s pins_in, // levels the pins settle to
   output pasd_pkg::pasd_straps_s pins_out, // strap pin levels
   output logic load_out, // one cycle load pulse
   output pasd_pkg::pasd_straps_s eeprom_out // loader data
);
   timeunit 1ns;
   timeprecision 1ns;
   import pasd_pkg::*;
   assign pins_out = pins_in;
   initial
   begin
      load_out = 1'b0;
      eeprom_out = '0;
   end
   always @(posedge clk_in)
   begin
      load_out <= go_in;
      eeprom_out <= go_in ? data_in : ~eeprom_out;
   end
endmodule : pasd_far_model
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: self-checking bench for the port A strap default block
// Assumes: register reads answer one cycle after the strobe
// Notes: expected defaults are rebuilt here from the strap mapping
`default_nettype none
`include "pasd_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pasd_pkg::*;
   localparam pasd_straps_s RST_S = {`PASD_RST_FIBER, `PASD_RST_AUTONEG, `PASD_RST_SPEED, `PASD_RST_DUPLEX,
      `PASD_RST_BACKPRESSURE, `PASD_RST_FDX_PAUSE, `PASD_RST_FORCED_PAUSE};
   localparam logic [6:0] TBL [8] = '{7'h00, 7'h09, 7'h16, 7'h1B, 7'h24, 7'h3F, 7'h7E, 7'h45};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic go = 1'b0;
   logic present = 1'b0;
   logic drst = 1'b0;
   logic reload = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   pasd_straps_s pins_cfg = RST_S;
   pasd_straps_s ld_data = '0;
   logic [31:0] rdata;
   logic load;
   logic cap;
   pasd_straps_s pins;
   pasd_straps_s ee;
   pasd_dflt_s dflt;
   int fail_count = 0;
   int n_compared = 0;
   pasd_far_model far (.clk_in(clk), .go_in(go), .data_in(ld_data), .pins_in(pins_cfg), .pins_out(pins),
      .load_out(load), .eeprom_out(ee));
   pasd_top DUT (.clk_in(clk), .nrst_in(nrst), .strap_pins_in(pins), .eeprom_present_in(present),
      .eeprom_load_in(load), .eeprom_straps_in(ee), .digital_rst_in(drst), .eeprom_reload_in(reload),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .dflt_out(dflt), .captured_out(cap));
   initial
   begin
      forever #50 clk = ~clk;
   end
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_dflt(input string what, input pasd_dflt_s exp);
      chk_word(what, {18'h0, exp}, {18'h0, dflt});
   endtask : chk_dflt
   function automatic pasd_dflt_s exp_of(input pasd_straps_s s);
      pasd_dflt_s d;
      logic fx;
      logic an;
      logic sp;
      logic dp;
      logic fp;
      logic mf;
      fx = s.phy_fiber_mode_strap;
      an = s.phy_autoneg_default_strap & ~fx;
      sp = s.phy_rate_default_strap;
      dp = s.phy_fdx_default_strap;
      fp = s.port_one_fdx_pause_default_strap;
      mf = s.port_one_forced_pause_default_strap;
      d.phy_autoneg_enable_bit = an;
      d.phy_rate_select_low_bit = fx | an | sp;
      d.phy_fdx_bit = an | dp;
      d.phy_adv_10_hdx_bit = ~fx & (an | ~sp);
      d.phy_adv_10_fdx_bit = ~fx & (an | ~sp) & dp;
      d.phy_asym_pause_bit = ~fx & fp & ~mf;
      d.phy_sym_pause_bit = ~fx & ~mf;
      d.phy_mode_field = fx ? `PASD_MODE_FIBER : (an ? `PASD_MODE_ALL_CAPABLE : {1'b0, sp, dp});
      d.port_one_backpressure_bit = s.port_one_backpressure_default_strap;
      d.port_one_tx_pause_enable_bit = fp;
      d.port_one_rx_pause_enable_bit = fp;
      d.port_one_forced_pause_select = mf;
      return d;
   endfunction : exp_of
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk_word(what, exp, rdata);
   endtask : reg_rd
   task automatic do_reset;
      int i;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (i = 0; i < 20 && cap !== 1'b1; i++)
         @(posedge clk);
      chk_word("captured_out", 32'h1, {31'h0, cap});
      if (cap !== 1'b1)
         wrap_up();
      repeat (2) @(posedge clk);
      #1;
   endtask : do_reset
   // go rises, model pulses one edge later, active and defaults follow
   task automatic load_straps(input pasd_straps_s d);
      @(posedge clk);
      go <= 1'b1;
      ld_data <= d;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : load_straps
   task automatic restore_by(input int m);
      if (m == 2)
         reg_wr(`PASD_ADDR_CONTROL, 32'h2);
      else
      begin
         @(posedge clk);
         if (m == 0)
            drst <= 1'b1;
         else
            reload <= 1'b1;
         @(posedge clk);
         drst <= 1'b0;
         reload <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
   endtask : restore_by
   task automatic t_power_up;
      chk_dflt("power-up defaults", exp_of(RST_S));
      reg_rd(`PASD_ADDR_LATCHED, {25'h0, RST_S}, "latched straps");
      reg_rd(`PASD_ADDR_CONTROL, 32'h0, "control at reset");
      reg_rd(`PASD_ADDR_STATUS, 32'h1, "status after capture");
   endtask : t_power_up
   task automatic t_table;
      pasd_straps_s s;
      pasd_dflt_s e;
      for (int i = 0; i < 8; i++)
      begin
         s = pasd_straps_s'(TBL[i]);
         e = exp_of(s);
         load_straps(s);
         chk_dflt("loaded defaults", e);
         reg_rd(`PASD_ADDR_ACTIVE, {25'h0, s}, "active straps");
         reg_rd(`PASD_ADDR_BASE_CTRL, {29'h0, e.phy_autoneg_enable_bit, e.phy_rate_select_low_bit,
            e.phy_fdx_bit}, "base control");
         reg_rd(`PASD_ADDR_ADVERTISE, {28'h0, e.phy_asym_pause_bit, e.phy_sym_pause_bit,
            e.phy_adv_10_fdx_bit, e.phy_adv_10_hdx_bit}, "advertise");
         reg_rd(`PASD_ADDR_OP_MODES, {29'h0, e.phy_mode_field}, "mode field");
         reg_rd(`PASD_ADDR_PORT_ONE, {28'h0, e.port_one_forced_pause_select, e.port_one_rx_pause_enable_bit,
            e.port_one_tx_pause_enable_bit, e.port_one_backpressure_bit}, "port one");
      end
   endtask : t_table
   task automatic t_freeze;
      reg_wr(`PASD_ADDR_CONTROL, 32'h1);
      reg_rd(`PASD_ADDR_CONTROL, 32'h1, "freeze readback");
      load_straps(7'h3F);
      chk_dflt("frozen defaults", exp_of(7'h45));
      reg_wr(`PASD_ADDR_CONTROL, 32'h0);
   endtask : t_freeze
   task automatic t_restore;
      pins_cfg <= 7'h01;
      reg_rd(`PASD_ADDR_STATUS, 32'h5, "status with override");
      present <= 1'b1;
      restore_by(0);
      chk_dflt("restore with eeprom", exp_of(7'h45));
      reg_rd(`PASD_ADDR_STATUS, 32'h7, "status with eeprom");
      present <= 1'b0;
      for (int m = 0; m < 3; m++)
      begin
         load_straps(7'h45);
         restore_by(m);
         chk_dflt("restored defaults", exp_of(RST_S));
      end
      reg_rd(`PASD_ADDR_CONTROL, 32'h0, "restore bit reads 0");
      do_reset();
      chk_dflt("second capture", exp_of(7'h01));
      reg_rd(`PASD_ADDR_LATCHED, 32'h1, "relatched straps");
   endtask : t_restore
   task automatic t_unmapped;
      reg_wr(`PASD_ADDR_LATCHED, 32'hFFFFFFFF);
      reg_wr(8'h20, 32'hFFFFFFFF);
      reg_rd(`PASD_ADDR_LATCHED, 32'h1, "read-only latched");
      reg_rd(8'h20, 32'h0, "unmapped read");
      @(posedge clk);
      #1 chk_word("read data after its cycle", 32'h0, rdata);
   endtask : t_unmapped
   // load pulse and digital reset meet at one edge: the newer loader data must win
   task automatic t_collide;
      @(posedge clk);
      go <= 1'b1;
      ld_data <= 7'h16;
      @(posedge clk);
      go <= 1'b0;
      drst <= 1'b1;
      @(posedge clk);
      drst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk_dflt("load beside restore", exp_of(7'h16));
   endtask : t_collide
   initial
   begin
      do_reset();
      t_power_up();
      t_table();
      t_freeze();
      t_restore();
      t_unmapped();
      t_collide();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
